/* File: hdl/iad_decoder.sv */
// Purpose: host I/O register address decoder and event strobe source
// Assumes: host strobes io_rd/io_wr are one-cycle, synchronous to clk
// Notes:   all answers and strobes appear one clock after the request
`timescale 1ns/1ps
// How it works
// - answer only inside base plus defined offsets
// - command words 0-6, state words 18, 1A
// - word read 0 is FIFO; write 8 scan
// - analog output data words at 10, 12
// - input strobes at 1B, 19, 1D by byte
// - output strobes at 1F, 18 word, 1E
// - general strobes 0B, 19, 09, 1E, 0A
// - offset 1C reads inputs, writes outputs
// - crossbar shift 0C, latch 0E byte writes
// - strobe access pulses; write data ignored
// - asterisk fields stored active low, unchanged
module iad_decoder (
    // clock and reset
    input  wire logic                      clk,
    input  wire logic                      rst,
    // host I/O bus
    input  wire logic [iad_pkg::ADDR_W-1:0] base_addr,
    input  wire logic [iad_pkg::ADDR_W-1:0] io_addr,
    input  wire logic                      io_rd,
    input  wire logic                      io_wr,
    input  wire logic                      io_word,
    input  wire logic [iad_pkg::DATA_W-1:0] io_wdata,
    output logic      [iad_pkg::DATA_W-1:0] io_rdata,
    output logic                           io_rdata_oe,
    // read sources
    input  wire logic [iad_pkg::DATA_W-1:0] fifo_data,
    input  wire logic [iad_pkg::DATA_W-1:0] counter_rdata,
    input  wire logic [iad_pkg::DATA_W-1:0] counter_state,
    input  wire logic [iad_pkg::DATA_W-1:0] board_state_one,
    input  wire logic [iad_pkg::DATA_W-1:0] board_state_two,
    input  wire logic [iad_pkg::DATA_W-1:0] digital_lines_in,
    // held words
    output logic      [iad_pkg::DATA_W-1:0] command_word_one,
    output logic      [iad_pkg::DATA_W-1:0] command_word_two,
    output logic      [iad_pkg::DATA_W-1:0] command_word_three,
    output logic      [iad_pkg::DATA_W-1:0] command_word_four,
    output logic      [iad_pkg::DATA_W-1:0] analog_out_zero_data,
    output logic      [iad_pkg::DATA_W-1:0] analog_out_one_data,
    output logic      [iad_pkg::DATA_W-1:0] digital_lines_out,
    // data with a load pulse
    output logic      [iad_pkg::DATA_W-1:0] write_data,
    output logic                           scan_list_memory_wr,
    output logic                           counter_data_wr,
    output logic                           counter_command_wr,
    output logic                           trigger_crossbar_shift,
    output logic                           trigger_crossbar_latch,
    // read side pulses
    output logic                           fifo_rd,
    output logic                           counter_data_rd,
    output logic                           counter_state_rd,
    // analog input event strobes
    output logic                           scan_list_reset,
    output logic                           scan_list_advance,
    output logic                           acquisition_clear,
    output logic                           acquisition_start,
    output logic                           one_shot_conversion,
    // analog output event strobes
    output logic                           timer_request_clear,
    output logic                           analog_out_update,
    output logic                           analog_out_clear,
    // general event strobes
    output logic                           dma_channel_clear,
    output logic                           dma_count_a_clear,
    output logic                           dma_count_b_clear,
    output logic                           external_pulse,
    output logic                           calibration_zero_load
);
    import iad_pkg::*;

    // ------------------------------------------------------------------
    // address window
    // ------------------------------------------------------------------
    logic [ADDR_W-1:0] diff;
    logic              in_win;
    logic [OFS_W-1:0]  ofs;

    always_comb begin
        diff   = io_addr - base_addr;
        in_win = (io_addr >= base_addr) && (diff <= WIN_LAST);
        ofs    = diff[OFS_W-1:0];
    end

    // true when the offset and transfer width both match one location;
    // a width mismatch is simply not decoded, so it has no effect
    function automatic logic acc(
        input logic             hit,
        input logic [OFS_W-1:0] at,
        input logic             word,
        input logic [OFS_W-1:0] want,
        input logic             want_word
    );
        acc = hit && (at == want) && (word == want_word);
    endfunction : acc

    logic wr_ok;
    logic rd_ok;

    always_comb begin
        wr_ok = io_wr && !io_rd;
        rd_ok = io_rd && !io_wr;
    end

    // ------------------------------------------------------------------
    // word holding registers
    // ------------------------------------------------------------------
    logic [HOLD_N-1:0]             hold_load;
    logic [HOLD_N-1:0][DATA_W-1:0] hold_q;

    genvar gi;
    generate
        for (gi = 0; gi < HOLD_N; gi++) begin : g_hold
            // only writes load; a read at the same offset never does
            assign hold_load[gi] = wr_ok &&
                acc(in_win, ofs, io_word, HOLD_OFS[gi], 1'b1);
            iad_hold_reg #(
                .W    (DATA_W)
            ) u_hold (
                .clk  (clk),
                .rst  (rst),
                .load (hold_load[gi]),
                .d    (io_wdata),
                .q    (hold_q[gi])
            );
        end
    endgenerate

    // bits stay as written, so asterisk fields keep low-active sense
    assign command_word_one     = hold_q[H_CMD1];
    assign command_word_two     = hold_q[H_CMD2];
    assign command_word_three   = hold_q[H_CMD3];
    assign command_word_four    = hold_q[H_CMD4];
    assign analog_out_zero_data = hold_q[H_AO0];
    assign analog_out_one_data  = hold_q[H_AO1];
    assign digital_lines_out    = hold_q[H_DIG];

    // ------------------------------------------------------------------
    // write pulses and strobes
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] wdata_q, wdata_d;
    logic scan_wr_q, scan_wr_d;
    logic cnt_dwr_q, cnt_dwr_d;
    logic cnt_cwr_q, cnt_cwr_d;
    logic xb_shft_q, xb_shft_d;
    logic xb_ltch_q, xb_ltch_d;
    logic scan_adv_q, scan_adv_d;
    logic one_shot_q, one_shot_d;
    logic ao_upd_q, ao_upd_d;
    logic dma_a_q, dma_a_d;
    logic ext_q, ext_d;
    logic cal0_q, cal0_d;

    always_comb begin
        scan_wr_d  = wr_ok && acc(in_win, ofs, io_word,
                                  OFS_SCAN_MEM, 1'b1);
        cnt_dwr_d  = wr_ok && acc(in_win, ofs, io_word,
                                  OFS_CNT_DATA, 1'b1);
        cnt_cwr_d  = wr_ok && acc(in_win, ofs, io_word,
                                  OFS_CNT_CMD, 1'b1);
        xb_shft_d  = wr_ok && acc(in_win, ofs, io_word,
                                  OFS_XBAR_SHFT, 1'b0);
        xb_ltch_d  = wr_ok && acc(in_win, ofs, io_word,
                                  OFS_XBAR_LTCH, 1'b0);
        scan_adv_d = wr_ok && acc(in_win, ofs, io_word,
                                  OFS_SCAN_ADV, 1'b0);
        one_shot_d = wr_ok && acc(in_win, ofs, io_word,
                                  OFS_ONE_SHOT, 1'b0);
        ao_upd_d   = wr_ok && acc(in_win, ofs, io_word,
                                  OFS_AO_UPDATE, 1'b1);
        dma_a_d    = wr_ok && acc(in_win, ofs, io_word,
                                  OFS_DMA_A_CLR, 1'b0);
        ext_d      = wr_ok && acc(in_win, ofs, io_word,
                                  OFS_EXT_PULSE, 1'b0);
        cal0_d     = wr_ok && acc(in_win, ofs, io_word,
                                  OFS_CAL0_LOAD, 1'b0);
        // data only forwarded with a data-carrying pulse; strobe
        // writes leave it untouched since their pattern is ignored
        if (scan_wr_d || cnt_dwr_d || cnt_cwr_d) begin
            wdata_d = io_wdata;
        end else if (xb_shft_d || xb_ltch_d) begin
            wdata_d = {8'h00, io_wdata[7:0]};
        end else begin
            wdata_d = wdata_q;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            wdata_q    <= ZERO_W;
            scan_wr_q  <= 1'b0;
            cnt_dwr_q  <= 1'b0;
            cnt_cwr_q  <= 1'b0;
            xb_shft_q  <= 1'b0;
            xb_ltch_q  <= 1'b0;
            scan_adv_q <= 1'b0;
            one_shot_q <= 1'b0;
            ao_upd_q   <= 1'b0;
            dma_a_q    <= 1'b0;
            ext_q      <= 1'b0;
            cal0_q     <= 1'b0;
        end else begin
            wdata_q    <= wdata_d;
            scan_wr_q  <= scan_wr_d;
            cnt_dwr_q  <= cnt_dwr_d;
            cnt_cwr_q  <= cnt_cwr_d;
            xb_shft_q  <= xb_shft_d;
            xb_ltch_q  <= xb_ltch_d;
            scan_adv_q <= scan_adv_d;
            one_shot_q <= one_shot_d;
            ao_upd_q   <= ao_upd_d;
            dma_a_q    <= dma_a_d;
            ext_q      <= ext_d;
            cal0_q     <= cal0_d;
        end
    end

    assign write_data             = wdata_q;
    assign scan_list_memory_wr    = scan_wr_q;
    assign counter_data_wr        = cnt_dwr_q;
    assign counter_command_wr     = cnt_cwr_q;
    assign trigger_crossbar_shift = xb_shft_q;
    assign trigger_crossbar_latch = xb_ltch_q;
    assign scan_list_advance      = scan_adv_q;
    assign one_shot_conversion    = one_shot_q;
    assign analog_out_update      = ao_upd_q;
    assign dma_count_a_clear      = dma_a_q;
    assign external_pulse         = ext_q;
    assign calibration_zero_load  = cal0_q;

    // ------------------------------------------------------------------
    // read decode, read pulses and read strobes
    // ------------------------------------------------------------------
    logic [DATA_W-1:0] rdata_q, rdata_d;
    logic oe_q, oe_d;
    logic fifo_rd_q, fifo_rd_d;
    logic cnt_drd_q, cnt_drd_d;
    logic cnt_srd_q, cnt_srd_d;
    logic scan_rst_q, scan_rst_d;
    logic acq_clr_q, acq_clr_d;
    logic acq_go_q, acq_go_d;
    logic tmr_clr_q, tmr_clr_d;
    logic ao_clr_q, ao_clr_d;
    logic dma_clr_q, dma_clr_d;
    logic dma_b_q, dma_b_d;
    logic word_rd;
    logic byte_rd;

    always_comb begin
        word_rd    = rd_ok && in_win && io_word;
        byte_rd    = rd_ok && in_win && !io_word;
        fifo_rd_d  = word_rd && (ofs == OFS_FIFO);
        cnt_drd_d  = word_rd && (ofs == OFS_CNT_DATA);
        cnt_srd_d  = word_rd && (ofs == OFS_CNT_CMD);
        scan_rst_d = rd_ok && acc(in_win, ofs, io_word,
                                  OFS_SCAN_RST, 1'b0);
        acq_clr_d  = rd_ok && acc(in_win, ofs, io_word,
                                  OFS_ACQ_CLR, 1'b0);
        acq_go_d   = rd_ok && acc(in_win, ofs, io_word,
                                  OFS_ACQ_START, 1'b0);
        tmr_clr_d  = rd_ok && acc(in_win, ofs, io_word,
                                  OFS_TMR_CLR, 1'b0);
        ao_clr_d   = rd_ok && acc(in_win, ofs, io_word,
                                  OFS_AO_CLEAR, 1'b0);
        dma_clr_d  = rd_ok && acc(in_win, ofs, io_word,
                                  OFS_DMA_CLR, 1'b0);
        dma_b_d    = rd_ok && acc(in_win, ofs, io_word,
                                  OFS_DMA_B_CLR, 1'b0);
        rdata_d    = ZERO_W;
        oe_d       = 1'b0;
        if (word_rd) begin
            unique case (ofs)
                OFS_FIFO:      begin rdata_d = fifo_data;        oe_d = 1'b1; end
                OFS_CNT_DATA:  begin rdata_d = counter_rdata;    oe_d = 1'b1; end
                OFS_CNT_CMD:   begin rdata_d = counter_state;    oe_d = 1'b1; end
                OFS_STATE_ONE: begin rdata_d = board_state_one;  oe_d = 1'b1; end
                OFS_STATE_TWO: begin rdata_d = board_state_two;  oe_d = 1'b1; end
                OFS_DIG:       begin rdata_d = digital_lines_in; oe_d = 1'b1; end
                default:       begin rdata_d = ZERO_W;           oe_d = 1'b0; end
            endcase
        end else if (scan_rst_d || acq_clr_d || acq_go_d || tmr_clr_d ||
                     ao_clr_d || dma_clr_d || dma_b_d) begin
            // strobe reads drive the bus with a fixed, meaningless word
            rdata_d = STROBE_RD;
            oe_d    = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_q    <= ZERO_W;
            oe_q       <= 1'b0;
            fifo_rd_q  <= 1'b0;
            cnt_drd_q  <= 1'b0;
            cnt_srd_q  <= 1'b0;
            scan_rst_q <= 1'b0;
            acq_clr_q  <= 1'b0;
            acq_go_q   <= 1'b0;
            tmr_clr_q  <= 1'b0;
            ao_clr_q   <= 1'b0;
            dma_clr_q  <= 1'b0;
            dma_b_q    <= 1'b0;
        end else begin
            rdata_q    <= rdata_d;
            oe_q       <= oe_d;
            fifo_rd_q  <= fifo_rd_d;
            cnt_drd_q  <= cnt_drd_d;
            cnt_srd_q  <= cnt_srd_d;
            scan_rst_q <= scan_rst_d;
            acq_clr_q  <= acq_clr_d;
            acq_go_q   <= acq_go_d;
            tmr_clr_q  <= tmr_clr_d;
            ao_clr_q   <= ao_clr_d;
            dma_clr_q  <= dma_clr_d;
            dma_b_q    <= dma_b_d;
        end
    end

    assign io_rdata            = rdata_q;
    assign io_rdata_oe         = oe_q;
    assign fifo_rd             = fifo_rd_q;
    assign counter_data_rd     = cnt_drd_q;
    assign counter_state_rd    = cnt_srd_q;
    assign scan_list_reset     = scan_rst_q;
    assign acquisition_clear   = acq_clr_q;
    assign acquisition_start   = acq_go_q;
    assign timer_request_clear = tmr_clr_q;
    assign analog_out_clear    = ao_clr_q;
    assign dma_channel_clear   = dma_clr_q;
    assign dma_count_b_clear   = dma_b_q;
endmodule : iad_decoder

/* File: hdl/iad_hold_reg.sv */
// Purpose: one write-only holding register of the decoder
// Assumes: load is a one-cycle pulse from the decode stage
// Notes:   value is kept as written, no bit is inverted
`timescale 1ns/1ps
module iad_hold_reg #(
    parameter int W = 16
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // load side
    input  wire logic         load,
    input  wire logic [W-1:0] d,
    // held value
    output logic      [W-1:0] q
);
    import iad_pkg::*;

    logic [W-1:0] val_q;
    logic [W-1:0] val_d;

    always_comb begin
        val_d = load ? d : val_q;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            val_q <= W'(HOLD_RST);
        end else begin
            val_q <= val_d;
        end
    end

    assign q = val_q;
endmodule : iad_hold_reg

/* File: hdl/iad_pkg.sv */
// Purpose: constants for the host register address decoder
// Assumes: 10-bit I/O addresses, 16-bit data path
// Notes:   offsets are byte offsets from the configured base address
package iad_pkg;
    // ------------------------------------------------------------------
    // bus geometry
    // ------------------------------------------------------------------
    localparam int             ADDR_W   = 10;
    localparam int             DATA_W   = 16;
    localparam int             OFS_W    = 5;
    localparam logic [9:0]     WIN_LAST = 10'h01F;
    localparam logic [15:0]    ZERO_W   = 16'h0000;
    localparam logic [15:0]    STROBE_RD = 16'h0000;

    // ------------------------------------------------------------------
    // word locations
    // ------------------------------------------------------------------
    localparam logic [4:0] OFS_CMD_ONE   = 5'h00;
    localparam logic [4:0] OFS_FIFO      = 5'h00;
    localparam logic [4:0] OFS_CMD_TWO   = 5'h02;
    localparam logic [4:0] OFS_CMD_THREE = 5'h04;
    localparam logic [4:0] OFS_CMD_FOUR  = 5'h06;
    localparam logic [4:0] OFS_SCAN_MEM  = 5'h08;
    localparam logic [4:0] OFS_AO_ZERO   = 5'h10;
    localparam logic [4:0] OFS_AO_ONE    = 5'h12;
    localparam logic [4:0] OFS_CNT_DATA  = 5'h14;
    localparam logic [4:0] OFS_CNT_CMD   = 5'h16;
    localparam logic [4:0] OFS_STATE_ONE = 5'h18;
    localparam logic [4:0] OFS_AO_UPDATE = 5'h18;
    localparam logic [4:0] OFS_STATE_TWO = 5'h1A;
    localparam logic [4:0] OFS_DIG       = 5'h1C;

    // ------------------------------------------------------------------
    // byte locations
    // ------------------------------------------------------------------
    localparam logic [4:0] OFS_DMA_B_CLR = 5'h09;
    localparam logic [4:0] OFS_CAL0_LOAD = 5'h0A;
    localparam logic [4:0] OFS_DMA_CLR   = 5'h0B;
    localparam logic [4:0] OFS_XBAR_SHFT = 5'h0C;
    localparam logic [4:0] OFS_XBAR_LTCH = 5'h0E;
    localparam logic [4:0] OFS_ACQ_CLR   = 5'h19;
    localparam logic [4:0] OFS_DMA_A_CLR = 5'h19;
    localparam logic [4:0] OFS_SCAN_RST  = 5'h1B;
    localparam logic [4:0] OFS_SCAN_ADV  = 5'h1B;
    localparam logic [4:0] OFS_ACQ_START = 5'h1D;
    localparam logic [4:0] OFS_ONE_SHOT  = 5'h1D;
    localparam logic [4:0] OFS_AO_CLEAR  = 5'h1E;
    localparam logic [4:0] OFS_EXT_PULSE = 5'h1E;
    localparam logic [4:0] OFS_TMR_CLR   = 5'h1F;

    // ------------------------------------------------------------------
    // word holding registers, index order of the generate loop
    // ------------------------------------------------------------------
    localparam int             HOLD_N   = 7;
    localparam int             H_CMD1   = 0;
    localparam int             H_CMD2   = 1;
    localparam int             H_CMD3   = 2;
    localparam int             H_CMD4   = 3;
    localparam int             H_AO0    = 4;
    localparam int             H_AO1    = 5;
    localparam int             H_DIG    = 6;
    localparam logic [6:0][4:0] HOLD_OFS = {OFS_DIG, OFS_AO_ONE,
        OFS_AO_ZERO, OFS_CMD_FOUR, OFS_CMD_THREE, OFS_CMD_TWO,
        OFS_CMD_ONE};
    localparam logic [15:0]    HOLD_RST = 16'h0000;
endpackage : iad_pkg

/* File: tb/iad_checker.sv */
// Purpose: bus-level checks of the host register decoder
// Assumes: answers one cycle after request
// Notes:   bound to each iad_decoder instance
`timescale 1ns/1ps
module iad_checker (
    // clock and reset
    input wire logic        clk,
    input wire logic        rst,
    // host bus
    input wire logic [9:0]  base_addr,
    input wire logic [9:0]  io_addr,
    input wire logic        io_rd,
    input wire logic        io_wr,
    input wire logic        io_word,
    input wire logic [15:0] io_wdata,
    input wire logic [15:0] io_rdata,
    input wire logic        io_rdata_oe,
    // sources and results
    input wire logic [15:0] board_state_one,
    input wire logic [15:0] command_word_two,
    input wire logic [15:0] write_data,
    input wire logic        fifo_rd,
    input wire logic        acquisition_start,
    input wire logic        analog_out_update,
    input wire logic        external_pulse,
    input wire logic        timer_request_clear,
    input wire logic        trigger_crossbar_shift
);
    // ----
    // request decode
    // ----
    logic [9:0] dif;
    logic [4:0] o;
    logic [7:0] lo;
    logic       hit, rw, rb, ww, wb;
    assign dif = io_addr - base_addr;
    assign hit = io_addr >= base_addr && dif <= 10'h01F;
    assign o   = dif[4:0];
    assign lo  = io_wdata[7:0];
    assign rw  = hit && io_rd && !io_wr && io_word;
    assign rb  = hit && io_rd && !io_wr && !io_word;
    assign ww  = hit && io_wr && !io_rd && io_word;
    assign wb  = hit && io_wr && !io_rd && !io_word;
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ----
    // properties
    // ----
    a_fifo_read: assert property (
        rw && o == 5'h00 |=> fifo_rd && io_rdata_oe)
        else $error("fifo read");
    a_state_read: assert property (
        rw && o == 5'h18 |=> io_rdata_oe
        && io_rdata == $past(board_state_one))
        else $error("state read");
    a_cmd_write: assert property (
        ww && o == 5'h02 |=> command_word_two == $past(io_wdata))
        else $error("cmd two load");
    a_start_pulse: assert property (
        rb && o == 5'h1D ##1 !(rb && o == 5'h1D)
        |-> acquisition_start ##1 !acquisition_start)
        else $error("start pulse");
    a_update_pulse: assert property (
        ww && o == 5'h18 |=> analog_out_update)
        else $error("update pulse");
    a_strobe_data: assert property (
        wb && o == 5'h1E |=> external_pulse && $stable(write_data))
        else $error("strobe data");
    a_shift_data: assert property (
        wb && o == 5'h0C |=> trigger_crossbar_shift
        && write_data == {8'h00, $past(lo)})
        else $error("shift byte");
    a_wrong_dir: assert property (
        wb && o == 5'h1F |=> !timer_request_clear && !io_rdata_oe)
        else $error("wrong direction");
    a_outside: assert property (
        (io_rd || io_wr) && !hit
        |=> !io_rdata_oe && !fifo_rd && !external_pulse)
        else $error("outside window");
    a_width: assert property (
        rb && o == 5'h00 |=> !fifo_rd && !io_rdata_oe)
        else $error("wrong width");
    c_fifo: cover property (rw && o == 5'h00);
    c_strobe: cover property (wb && o == 5'h1E);
    c_out: cover property ((io_rd || io_wr) && !hit);
endmodule : iad_checker

bind iad_decoder iad_checker i_chk (.*);

/* File: tb/iad_decoder_tb.sv */
// Purpose: self-checking bench of the host register decoder
// Assumes: 100 MHz clock, reset held 20 cycles
// Notes:   host side played by iad_host_model
`timescale 1ns/1ps
`define CHK(nm, e, a) begin n_checks++; if ((a) !== (e)) begin \
    failures++; $display("mismatch %s exp %h got %h", nm, e, a); end end
module iad_decoder_tb;
    import iad_pkg::*;
    localparam logic [9:0] BASE = 10'h240;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [9:0] base_addr, io_addr;
    logic io_rd, io_wr, io_word, io_rdata_oe, oe;
    logic [15:0] io_wdata, io_rdata, q, write_data, ev;
    logic [15:0] fifo_data = 16'hF1F0, counter_rdata = 16'hC0DA;
    logic [15:0] counter_state = 16'hC057, board_state_one = 16'h5101;
    logic [15:0] board_state_two = 16'h5202, digital_lines_in = 16'hD1D1;
    logic [15:0] command_word_one, command_word_two, command_word_three;
    logic [15:0] command_word_four, analog_out_zero_data;
    logic [15:0] analog_out_one_data, digital_lines_out;
    logic scan_list_memory_wr, counter_data_wr, counter_command_wr;
    logic trigger_crossbar_shift, trigger_crossbar_latch, fifo_rd;
    logic counter_data_rd, counter_state_rd, scan_list_reset;
    logic scan_list_advance, acquisition_clear, acquisition_start;
    logic one_shot_conversion, timer_request_clear, analog_out_update;
    logic analog_out_clear, dma_channel_clear, dma_count_a_clear;
    logic dma_count_b_clear, external_pulse, calibration_zero_load;
    logic [6:0][15:0] held, snap;
    logic [2:0] rp;
    int failures = 0;
    int n_checks = 0;
    always #5 clk = ~clk;
    assign held = {digital_lines_out, analog_out_one_data,
        analog_out_zero_data, command_word_four, command_word_three,
        command_word_two, command_word_one};
    assign rp = {fifo_rd, counter_data_rd, counter_state_rd};
    assign ev = {scan_list_reset, scan_list_advance, acquisition_clear,
        acquisition_start, one_shot_conversion, timer_request_clear,
        analog_out_update, analog_out_clear, dma_channel_clear,
        dma_count_a_clear, dma_count_b_clear, external_pulse,
        calibration_zero_load, scan_list_memory_wr,
        trigger_crossbar_shift, trigger_crossbar_latch};
    iad_host_model #(.BASE(BASE)) i_host (.*);
    iad_decoder i_dut (.*);
    task automatic go(input logic r, w, wd, input logic [9:0] a,
            input logic [15:0] d);
        i_host.acc(r, w, wd, a, d, q, oe);
    endtask : go
    task automatic t_words;
        for (int i = 0; i < 7; i++) begin
            go(0, 1, 1, BASE + 10'(HOLD_OFS[i]), 16'hA500 + 16'(i));
            `CHK("held", 16'hA500 + 16'(i), held[i])
        end
        for (int i = 0; i < 7; i++)
            `CHK("kept", 16'hA500 + 16'(i), held[i])
        $display("test words done");
    endtask : t_words
    task automatic t_reads;
        logic [4:0] ro[6] = '{5'h00, 5'h18, 5'h1A, 5'h1C, 5'h14, 5'h16};
        logic [15:0] rv[6] = '{16'hF1F0, 16'h5101, 16'h5202, 16'hD1D1,
            16'hC0DA, 16'hC057};
        logic [2:0] rx[6] = '{3'h4, 3'h0, 3'h0, 3'h0, 3'h2, 3'h1};
        for (int i = 0; i < 6; i++) begin
            go(1, 0, 1, BASE + 10'(ro[i]), 16'h0000);
            `CHK("rdata", rv[i], q)
            `CHK("oe", 1'b1, oe)
            `CHK("rpulse", rx[i], rp)
        end
        $display("test reads done");
    endtask : t_reads
    task automatic t_strobes;
        logic [6:0] st[16] = '{7'h1B, 7'h5B, 7'h19, 7'h1D, 7'h5D, 7'h1F,
            7'h78, 7'h1E, 7'h0B, 7'h59, 7'h09, 7'h5E, 7'h4A, 7'h68,
            7'h4C, 7'h4E};
        for (int i = 0; i < 16; i++) begin
            go(!st[i][6], st[i][6], st[i][5], BASE + 10'(st[i][4:0]),
                16'hFFFF ^ 16'(i));
            `CHK("strobe", 16'h8000 >> i, ev)
            `CHK("soe", !st[i][6], oe)
        end
        $display("test strobes done");
    endtask : t_strobes
    task automatic t_refuse;
        logic [12:0] rf[10] = '{13'h123F, 13'h0A60, 13'h127D, 13'h165D,
            13'h0A42, 13'h1240, 13'h0E4C, 13'h1642, 13'h0A5F, 13'h1A5E};
        snap = held;
        for (int i = 0; i < 10; i++) begin
            go(rf[i][12], rf[i][11], rf[i][10], rf[i][9:0], 16'h0BAD);
            `CHK("refev", 16'h0000, ev)
            `CHK("refoe", 1'b0, oe)
            `CHK("refrd", 3'h0, rp)
        end
        `CHK("refheld", snap, held)
        $display("test refuse done");
    endtask : t_refuse
    task automatic t_data;
        go(0, 1, 0, BASE + 10'h0C, 16'h12AB);
        `CHK("shift", 16'h00AB, write_data)
        go(0, 1, 1, BASE + 10'h08, 16'h3C5A);
        `CHK("scan", 16'h3C5A, write_data)
        go(0, 1, 0, BASE + 10'h1E, 16'h7777);
        `CHK("strobed", 16'h3C5A, write_data)
        go(0, 1, 1, BASE + 10'h14, 16'h1414);
        `CHK("cntd", 17'h11414, {counter_data_wr, write_data})
        go(0, 1, 1, BASE + 10'h16, 16'h1616);
        `CHK("cntc", 1'b1, counter_command_wr)
        $display("test data done");
    endtask : t_data
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        tally_and_finish();
    end
    initial begin
        repeat (20) @(posedge clk);
        #1 rst = 1'b0;
        `CHK("rstheld", 112'h0, held)
        t_words();
        t_reads();
        t_strobes();
        t_refuse();
        t_data();
        @(posedge clk);
        #1 rst = 1'b1;
        repeat (2) @(posedge clk);
        `CHK("midrst", 112'h0, held)
        #1 rst = 1'b0;
        go(0, 1, 1, BASE + 10'h02, 16'h5AA5);
        `CHK("after", 16'h5AA5, command_word_two)
        tally_and_finish();
    end
endmodule : iad_decoder_tb

/* File: tb/iad_host_model.sv */
// Purpose: host processor on the I/O bus, one access at a time
// Assumes: decoder answers one cycle after the request edge
// Notes:   released address and data lines carry inverted junk, never the old value; io_word keeps its value
`timescale 1ns/1ps
module iad_host_model #(
    parameter logic [9:0] BASE = 10'h240
) (
    // clock
    input wire logic         clk,
    // host bus
    output logic [9:0]       base_addr,
    output logic [9:0]       io_addr,
    output logic             io_rd,
    output logic             io_wr,
    output logic             io_word,
    output logic [15:0]      io_wdata,
    input wire logic [15:0]  io_rdata,
    input wire logic         io_rdata_oe
);
    initial begin
        base_addr = BASE;
        io_addr = ~BASE;
        {io_rd, io_wr, io_word} = 3'h0;
        io_wdata = 16'h0000;
    end
    // width is the caller's choice
    task automatic acc(input logic r, input logic w, input logic wd,
            input logic [9:0] a, input logic [15:0] d,
            output logic [15:0] q, output logic oe);
        @(posedge clk);
        #1;
        io_rd = r;
        io_wr = w;
        io_word = wd;
        io_addr = a;
        io_wdata = d;
        @(posedge clk);
        #1;
        {io_rd, io_wr} = 2'h0;
        io_addr = ~a;
        io_wdata = ~d;
        // whole word handed back; caller masks what it ignores
        q = io_rdata;
        oe = io_rdata_oe;
    endtask : acc
endmodule : iad_host_model
